// ---- epm_monitor.sv ----
// Purpose: per-second classification and 15-minute/24-hour counting for one framed 2048 kbit/s path
// Assumes: framer event inputs come from logic on clk_in, one pulse per frame event
// Notes: reports leave one per cycle on the log port, no back-pressure
//
// Operation
// - count a receive anomaly for every errored CRC-4 block reported
// - count a transmit anomaly for every far-end block error bit received
// - detect receive defects: frame alignment lost and signal lost
// - detect a transmit defect whenever the remote alarm bit is set
// - accumulate events per second and classify each second
// - receive second with frame or signal loss is errored and severe
// - receive: one CRC error makes errored; 805 or more make severe
// - transmit: one far-end error makes errored; 830 or more make severe
// - transmit: one remote alarm makes errored; severe limit is a parameter
// - background block errors count CRC errors outside receive-severe seconds, receive only
// - enter unavailable time at the end of ten consecutive severe seconds
// - path unavailable if either direction is unavailable
// - counting is suppressed during unavailable time
// - separate errored and severe counters for 15-minute and 24-hour windows
// - 15-minute counters clear each period, each with own limit
// - 15-minute handling selectable: without or with hysteresis
// - no hysteresis: crossing sends stamped report, counting continues
// - no hysteresis: period end logs both 15-minute counters
// - hysteresis errored: one report, then clear report when period ends at or below W
// - hysteresis severe: one report, then clear report when period ends at zero
// - 24-hour counters clear each day, each with own limit
// - 24-hour crossing sends one stamped report per day per counter
// - optional pattern generator, not built here
`timescale 1ns/1ps
`include "epm_params.svh"

module epm_monitor #(
	parameter int SEC_CYCLES = `EPM_SEC_CYCLES,
	parameter logic [15:0] RAI_SES_LIMIT = 16'(`EPM_RAI_SES_LIMIT)
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic wb_ack_out,
	output logic [31:0] wb_dat_out,
	input wire logic crc_block_err_in,
	input wire logic far_block_err_in,
	input wire logic frame_align_lost_in,
	input wire logic signal_lost_in,
	input wire logic remote_alarm_in,
	output logic log_valid_out,
	output epm_pkg::epm_report_t log_kind_out,
	output logic [31:0] log_value_out,
	output logic [31:0] log_stamp_out,
	output logic path_unavail_out
);
	import epm_pkg::*;

	epm_state_t s_q;
	epm_state_t s_d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// counters stop at all ones so a long outage never reads as a small count
	function automatic logic [15:0] sat16(input logic [15:0] v, input logic inc);
		sat16 = (inc && v != 16'hFFFF) ? v + 16'h0001 : v;
	endfunction

	// only lanes 0 and 1 reach the 16-bit limits
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
		wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic tick;
		logic end15;
		logic end24;
		logic rx_es;
		logic rx_ses;
		logic tx_es;
		logic tx_ses;
		logic es;
		logic severe_errored_second;
		logic avail;
		logic [31:0] stamp;
		logic [32:0] bbe_sum;
		logic wr;
		logic rd;
		logic [6:0] set;
		logic [6:0][31:0] setv;
		logic done;
		logic bbe_acc;
		tick = 1'b0;
		end15 = 1'b0;
		end24 = 1'b0;
		rx_es = 1'b0;
		rx_ses = 1'b0;
		tx_es = 1'b0;
		tx_ses = 1'b0;
		es = 1'b0;
		severe_errored_second = 1'b0;
		avail = 1'b0;
		stamp = 32'h0000_0000;
		bbe_sum = 33'h0_0000_0000;
		set = 7'h00;
		setv = '0;
		done = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		bbe_acc = 1'b0;
		s_d = s_q;

		// ---------------------------------------------------------------
		// time base
		// ---------------------------------------------------------------
		tick = (s_q.div == 32'(SEC_CYCLES - 1));
		s_d.div = tick ? 32'h0000_0000 : s_q.div + 32'h0000_0001;
		end15 = tick && (s_q.sec15 == 10'(`EPM_SECS_15M - 1));
		end24 = tick && (s_q.tod == 17'(`EPM_SECS_24H - 1));
		stamp = {s_q.day, s_q.tod};
		// day number wraps after 32768 days; it only feeds the stamp
		if (tick) begin
			s_d.sec15 = end15 ? 10'h000 : s_q.sec15 + 10'h001;
			s_d.tod = end24 ? 17'h0_0000 : s_q.tod + 17'h0_0001;
			s_d.day = end24 ? s_q.day + 15'h0001 : s_q.day;
		end

		// ---------------------------------------------------------------
		// per-second classification
		// ---------------------------------------------------------------
		rx_ses = s_q.rx_lof || s_q.rx_los || s_q.rx_crc >= 16'(`EPM_CRC_SES_LIMIT);
		rx_es = rx_ses || s_q.rx_crc != 16'h0000;
		// the alarm severe limit is still undecided, hence a parameter
		tx_ses = s_q.tx_ebit >= 16'(`EPM_EBIT_SES_LIMIT) || s_q.tx_rai >= RAI_SES_LIMIT;
		tx_es = tx_ses || s_q.tx_ebit != 16'h0000 || s_q.tx_rai != 16'h0000;
		es = rx_es || tx_es;
		severe_errored_second = rx_ses || tx_ses;

		// events landing on the tick open the new second, so none is lost
		if (tick) begin
			s_d.rx_crc = {15'h0000, crc_block_err_in};
			s_d.tx_ebit = {15'h0000, far_block_err_in};
			s_d.tx_rai = {15'h0000, remote_alarm_in};
			s_d.rx_lof = frame_align_lost_in;
			s_d.rx_los = signal_lost_in;
		end else begin
			s_d.rx_crc = sat16(s_q.rx_crc, crc_block_err_in);
			s_d.tx_ebit = sat16(s_q.tx_ebit, far_block_err_in);
			s_d.tx_rai = sat16(s_q.tx_rai, remote_alarm_in);
			s_d.rx_lof = s_q.rx_lof || frame_align_lost_in;
			s_d.rx_los = s_q.rx_los || signal_lost_in;
		end

		// ---------------------------------------------------------------
		// unavailable time, per direction
		// ---------------------------------------------------------------
		// a run counts seconds that disagree with the present state of the direction
		// limitation: the severe seconds before entry stay counted, there is no look-back
		if (tick) begin
			if (s_q.rx_unav == rx_ses) begin
				s_d.rx_run = 4'h0;
			end else if (s_q.rx_run == 4'(`EPM_UNAV_RUN - 1)) begin
				s_d.rx_run = 4'h0;
				s_d.rx_unav = !s_q.rx_unav;
			end else begin
				s_d.rx_run = s_q.rx_run + 4'h1;
			end

			if (s_q.tx_unav == tx_ses) begin
				s_d.tx_run = 4'h0;
			end else if (s_q.tx_run == 4'(`EPM_UNAV_RUN - 1)) begin
				s_d.tx_run = 4'h0;
				s_d.tx_unav = !s_q.tx_unav;
			end else begin
				s_d.tx_run = s_q.tx_run + 4'h1;
			end
		end

		// availability after this second's update decides whether it is counted
		avail = !(s_d.rx_unav || s_d.tx_unav);
		s_d.unav = !avail;

		// ---------------------------------------------------------------
		// counters and thresholds
		// ---------------------------------------------------------------
		// background errors only in available seconds that are not severe on receive
		bbe_acc = tick && avail && !rx_ses;
		if (tick && avail) begin
			s_d.c1 = sat16(s_q.c1, es);
			s_d.c2 = sat16(s_q.c2, severe_errored_second);
			s_d.c3 = sat16(s_q.c3, es);
			s_d.c4 = sat16(s_q.c4, severe_errored_second);
			if (!rx_ses) begin
				bbe_sum = {1'b0, s_q.bbe} + {17'h0_0000, s_q.rx_crc};
				s_d.bbe = bbe_sum[32] ? 32'hFFFF_FFFF : bbe_sum[31:0];
			end
		end
		// crossings are judged only in available seconds, like the counting itself
		if (tick && avail) begin
			if (s_d.c1 > s_q.lim_es15 && !s_q.es15_flag) begin
				s_d.es15_flag = 1'b1;
				set[EPM_REP_ES15_CROSS] = 1'b1;
				setv[EPM_REP_ES15_CROSS] = {16'h0000, s_d.c1};
			end

			if (s_d.c2 > s_q.lim_ses15 && !s_q.ses15_flag) begin
				s_d.ses15_flag = 1'b1;
				set[EPM_REP_SES15_CROSS] = 1'b1;
				setv[EPM_REP_SES15_CROSS] = {16'h0000, s_d.c2};
			end

			if (s_d.c3 > s_q.lim_es24 && !s_q.es24_flag) begin
				s_d.es24_flag = 1'b1;
				set[EPM_REP_ES24_CROSS] = 1'b1;
				setv[EPM_REP_ES24_CROSS] = {16'h0000, s_d.c3};
			end

			if (s_d.c4 > s_q.lim_ses24 && !s_q.ses24_flag) begin
				s_d.ses24_flag = 1'b1;
				set[EPM_REP_SES24_CROSS] = 1'b1;
				setv[EPM_REP_SES24_CROSS] = {16'h0000, s_d.c4};
			end
		end

		// ---------------------------------------------------------------
		// period boundaries
		// ---------------------------------------------------------------
		// counts here include the final second of the period
		if (end15) begin
			if (!s_q.hyst) begin
				set[EPM_REP_PERIOD_LOG] = 1'b1;
				setv[EPM_REP_PERIOD_LOG] = {s_d.c2, s_d.c1};
				s_d.es15_flag = 1'b0;
				s_d.ses15_flag = 1'b0;
			end else begin
				// no period log in this mode, only cross and clear reports
				// a report sent in the final second holds off the clear until a later one
				if (s_q.es15_flag && s_d.c1 <= s_q.lim_w) begin
					s_d.es15_flag = 1'b0;
					set[EPM_REP_ES15_CLEAR] = 1'b1;
					setv[EPM_REP_ES15_CLEAR] = {16'h0000, s_d.c1};
				end
				if (s_q.ses15_flag && s_d.c2 == 16'h0000) begin
					s_d.ses15_flag = 1'b0;
					set[EPM_REP_SES15_CLEAR] = 1'b1;
					setv[EPM_REP_SES15_CLEAR] = {16'h0000, s_d.c2};
				end
			end
			s_d.c1 = 16'h0000;
			s_d.c2 = 16'h0000;
		end
		if (end24) begin
			s_d.c3 = 16'h0000;
			s_d.c4 = 16'h0000;
			s_d.es24_flag = 1'b0;
			s_d.ses24_flag = 1'b0;
		end

		// ---------------------------------------------------------------
		// report queue: one pending slot per kind, lowest kind first
		// ---------------------------------------------------------------
		// at most seven reports a second, far fewer than the cycles in one
		s_d.log_valid = 1'b0;
		for (int k = 0; k < 7; k++) begin
			if (s_q.pend[k] && !done) begin
				done = 1'b1;
				s_d.pend[k] = 1'b0;
				s_d.log_valid = 1'b1;
				s_d.log_kind = 3'(k);
				s_d.log_value = s_q.pval[k];
				s_d.log_stamp = s_q.pstamp[k];
			end
		end
		for (int k = 0; k < 7; k++) begin
			if (set[k]) begin
				// new event beats the slot being emptied in the same cycle
				s_d.pend[k] = 1'b1;
				s_d.pval[k] = setv[k];
				s_d.pstamp[k] = stamp;
			end
		end

		// ---------------------------------------------------------------
		// wishbone slave, one wait state, ack dropped after one cycle
		// ---------------------------------------------------------------
		// writes land on the edge at which the master sees ack, as classic cycles expect
		wr = wb_cyc_in && wb_stb_in && wb_we_in && s_q.ack;
		// read data is built one cycle ahead and shown only with ack
		rd = wb_cyc_in && wb_stb_in && !wb_we_in && !s_q.ack;
		s_d.ack = wb_cyc_in && wb_stb_in && !s_q.ack;
		s_d.rdat = 32'h0000_0000;
		if (wr) begin
			unique case (wb_adr_in)
				`EPM_REG_CTRL: begin
					if (wb_sel_in[0]) begin
						s_d.hyst = wb_dat_in[`EPM_CTRL_HYST];
						// a clear loses to accumulation in the same cycle
						if (wb_dat_in[`EPM_CTRL_BBE_CLR] && !bbe_acc) begin
							s_d.bbe = 32'h0000_0000;
						end
					end
				end
				`EPM_REG_LIM_ES15: s_d.lim_es15 = wr16(s_q.lim_es15, wb_dat_in, wb_sel_in);
				`EPM_REG_LIM_SES15: s_d.lim_ses15 = wr16(s_q.lim_ses15, wb_dat_in, wb_sel_in);
				`EPM_REG_LIM_W: s_d.lim_w = wr16(s_q.lim_w, wb_dat_in, wb_sel_in);
				`EPM_REG_LIM_ES24: s_d.lim_es24 = wr16(s_q.lim_es24, wb_dat_in, wb_sel_in);
				`EPM_REG_LIM_SES24: s_d.lim_ses24 = wr16(s_q.lim_ses24, wb_dat_in, wb_sel_in);
				default: begin
				end
			endcase
		end
		if (rd) begin
			unique case (wb_adr_in)
				`EPM_REG_CTRL: s_d.rdat = {31'h0000_0000, s_q.hyst};
				`EPM_REG_LIM_ES15: s_d.rdat = {16'h0000, s_q.lim_es15};
				`EPM_REG_LIM_SES15: s_d.rdat = {16'h0000, s_q.lim_ses15};
				`EPM_REG_LIM_W: s_d.rdat = {16'h0000, s_q.lim_w};
				`EPM_REG_LIM_ES24: s_d.rdat = {16'h0000, s_q.lim_es24};
				`EPM_REG_LIM_SES24: s_d.rdat = {16'h0000, s_q.lim_ses24};
				`EPM_REG_STATUS: begin
					s_d.rdat[0] = s_q.rx_unav;
					s_d.rdat[1] = s_q.tx_unav;
					s_d.rdat[2] = s_q.unav;
					s_d.rdat[3] = s_q.es15_flag;
					s_d.rdat[4] = s_q.ses15_flag;
					s_d.rdat[5] = s_q.es24_flag;
					s_d.rdat[6] = s_q.ses24_flag;
				end
				`EPM_REG_C1: s_d.rdat = {16'h0000, s_q.c1};
				`EPM_REG_C2: s_d.rdat = {16'h0000, s_q.c2};
				`EPM_REG_C3: s_d.rdat = {16'h0000, s_q.c3};
				`EPM_REG_C4: s_d.rdat = {16'h0000, s_q.c4};
				`EPM_REG_BBE: s_d.rdat = s_q.bbe;
				`EPM_REG_TOD: s_d.rdat = stamp;
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s_q <= '0;
			// limits return to their defaults; software must write them again
			s_q.lim_es15 <= `EPM_RST_LIM_ES15;
			s_q.lim_ses15 <= `EPM_RST_LIM_SES15;
			s_q.lim_w <= `EPM_RST_LIM_W;
			s_q.lim_es24 <= `EPM_RST_LIM_ES24;
			s_q.lim_ses24 <= `EPM_RST_LIM_SES24;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign wb_ack_out = s_q.ack;
	assign wb_dat_out = s_q.rdat;
	assign log_valid_out = s_q.log_valid;
	assign log_kind_out = epm_report_t'(s_q.log_kind);
	assign log_value_out = s_q.log_value;
	assign log_stamp_out = s_q.log_stamp;
	assign path_unavail_out = s_q.unav;
endmodule

// ---- epm_params.svh ----
// Purpose: constants for the path performance monitor
// Assumes: 100 MHz system clock
// Notes: byte offsets on a 32-bit classic Wishbone slave
`ifndef EPM_PARAMS_SVH
`define EPM_PARAMS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define EPM_CLK_HZ 100000000
`define EPM_TICK_S 1
`define EPM_SEC_CYCLES (`EPM_CLK_HZ * `EPM_TICK_S)
`define EPM_SECS_15M 900
`define EPM_SECS_24H 86400

// ---------------------------------------------------------------
// classification figures
// ---------------------------------------------------------------
`define EPM_CRC_SES_LIMIT 805
`define EPM_EBIT_SES_LIMIT 830
`define EPM_RAI_SES_LIMIT 1000
`define EPM_UNAV_RUN 10

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EPM_REG_CTRL 8'h00
`define EPM_REG_LIM_ES15 8'h04
`define EPM_REG_LIM_SES15 8'h08
`define EPM_REG_LIM_W 8'h0C
`define EPM_REG_LIM_ES24 8'h10
`define EPM_REG_LIM_SES24 8'h14
`define EPM_REG_STATUS 8'h18
`define EPM_REG_C1 8'h1C
`define EPM_REG_C2 8'h20
`define EPM_REG_C3 8'h24
`define EPM_REG_C4 8'h28
`define EPM_REG_BBE 8'h2C
`define EPM_REG_TOD 8'h30

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define EPM_CTRL_HYST 0
`define EPM_CTRL_BBE_CLR 1
`define EPM_RST_LIM_ES15 16'h0032
`define EPM_RST_LIM_SES15 16'h000A
`define EPM_RST_LIM_W 16'h0014
`define EPM_RST_LIM_ES24 16'h0096
`define EPM_RST_LIM_SES24 16'h0014
`endif

// ---- epm_pkg.sv ----
// Purpose: types for the path performance monitor
// Assumes: nothing
// Notes: whole module state is one packed struct
package epm_pkg;
	typedef enum logic [2:0] {
		EPM_REP_ES15_CROSS = 3'h0,
		EPM_REP_SES15_CROSS = 3'h1,
		EPM_REP_ES15_CLEAR = 3'h2,
		EPM_REP_SES15_CLEAR = 3'h3,
		EPM_REP_ES24_CROSS = 3'h4,
		EPM_REP_SES24_CROSS = 3'h5,
		EPM_REP_PERIOD_LOG = 3'h6
	} epm_report_t;

	typedef struct packed {
		logic [31:0] div;
		logic [9:0] sec15;
		logic [16:0] tod;
		logic [14:0] day;
		logic [15:0] rx_crc;
		logic [15:0] tx_ebit;
		logic [15:0] tx_rai;
		logic rx_lof;
		logic rx_los;
		logic [3:0] rx_run;
		logic [3:0] tx_run;
		logic rx_unav;
		logic tx_unav;
		logic [15:0] c1;
		logic [15:0] c2;
		logic [15:0] c3;
		logic [15:0] c4;
		logic [31:0] bbe;
		logic es15_flag;
		logic ses15_flag;
		logic es24_flag;
		logic ses24_flag;
		logic hyst;
		logic [15:0] lim_es15;
		logic [15:0] lim_ses15;
		logic [15:0] lim_w;
		logic [15:0] lim_es24;
		logic [15:0] lim_ses24;
		logic [6:0] pend;
		logic [6:0][31:0] pval;
		logic [6:0][31:0] pstamp;
		logic ack;
		logic [31:0] rdat;
		logic log_valid;
		logic [2:0] log_kind;
		logic [31:0] log_value;
		logic [31:0] log_stamp;
		logic unav;
	} epm_state_t;
endpackage

// ---- epm_monitor_chk.sv ----
// Purpose: port-level checks for the path performance monitor
// Assumes: limits are written with all byte lanes enabled
// Notes: two limit registers are shadowed from the bus writes
`timescale 1ns/1ps
`include "epm_params.svh"

module epm_monitor_chk #(
	parameter int SEC_CYCLES = `EPM_SEC_CYCLES
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_ack_out,
	input wire logic [31:0] wb_dat_out,
	input wire logic crc_block_err_in,
	input wire logic far_block_err_in,
	input wire logic frame_align_lost_in,
	input wire logic signal_lost_in,
	input wire logic remote_alarm_in,
	input wire logic log_valid_out,
	input wire epm_pkg::epm_report_t log_kind_out,
	input wire logic [31:0] log_value_out,
	input wire logic [31:0] log_stamp_out,
	input wire logic path_unavail_out
);
	import epm_pkg::*;
	typedef struct packed {
		logic [31:0] quiet;
		logic [15:0] les;
		logic [15:0] lss;
	} epm_chk_t;
	epm_chk_t s_q;
	epm_chk_t s_d;
	logic wr;
	assign wr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in;
	// quiet counts cycles since the last framer event of any kind
	always_comb begin
		s_d = s_q;
		if (s_q.quiet != 32'hFFFFFFFF) begin
			s_d.quiet = s_q.quiet + 32'h1;
		end
		if (crc_block_err_in || far_block_err_in || frame_align_lost_in || signal_lost_in || remote_alarm_in) begin
			s_d.quiet = 32'h0;
		end
		if (wr && wb_adr_in == `EPM_REG_LIM_ES15) begin
			s_d.les = wb_dat_in[15:0];
		end
		if (wr && wb_adr_in == `EPM_REG_LIM_SES24) begin
			s_d.lss = wb_dat_in[15:0];
		end
	end
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s_q <= {32'h0, `EPM_RST_LIM_ES15, `EPM_RST_LIM_SES24};
		end else begin
			s_q <= s_d;
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_ans;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	property p_answer;
		s_req |=> s_ans;
	endproperty
	property p_no_stray;
		wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
	endproperty
	property p_rdat_idle;
		!wb_ack_out |-> wb_dat_out == 32'h0;
	endproperty
	property p_rst_quiet;
		$rose(nrst_in) |-> !wb_ack_out && !log_valid_out && !path_unavail_out;
	endproperty
	// ten severe seconds cannot end without a recent event
	property p_unav_cause;
		$rose(path_unavail_out) |-> s_q.quiet < 32'(2 * SEC_CYCLES);
	endproperty
	property p_es15_cross;
		log_valid_out && log_kind_out == EPM_REP_ES15_CROSS |-> log_value_out > {16'h0, s_q.les};
	endproperty
	property p_ses24_cross;
		log_valid_out && log_kind_out == EPM_REP_SES24_CROSS |-> log_value_out > {16'h0, s_q.lss};
	endproperty
	property p_stamp;
		log_valid_out |-> log_stamp_out[16:0] < 17'(`EPM_SECS_24H);
	endproperty
	a_answer: assert property (p_answer) else $error("bus request not answered by a one-cycle ack");
	a_no_stray: assert property (p_no_stray) else $error("ack without a request");
	a_rdat_idle: assert property (p_rdat_idle) else $error("read data not zero outside ack");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
	a_unav_cause: assert property (p_unav_cause) else $error("unavailable without severe events");
	a_es15_cross: assert property (p_es15_cross) else $error("errored 15m report at or below limit");
	a_ses24_cross: assert property (p_ses24_cross) else $error("severe day report at or below limit");
	a_stamp: assert property (p_stamp) else $error("report stamp second out of range");
endmodule

bind epm_monitor epm_monitor_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
	.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
	.wb_dat_out(wb_dat_out), .crc_block_err_in(crc_block_err_in), .far_block_err_in(far_block_err_in),
	.frame_align_lost_in(frame_align_lost_in), .signal_lost_in(signal_lost_in),
	.remote_alarm_in(remote_alarm_in), .log_valid_out(log_valid_out), .log_kind_out(log_kind_out),
	.log_value_out(log_value_out), .log_stamp_out(log_stamp_out), .path_unavail_out(path_unavail_out)
);

// ---- epm_framer_model.sv ----
// Purpose: framer event source and management log sink
// Assumes: same clock as the monitor
// Notes: the sink never stalls, the log port has no back-pressure
`timescale 1ns/1ps

module epm_framer_model (
	input wire logic clk_in,
	output logic [4:0] ev_out,
	input wire logic log_valid_in,
	input wire logic [2:0] log_kind_in,
	input wire logic [31:0] log_value_in
);
	int rep_cnt [7];
	logic [31:0] rep_val [7];
	initial begin
		ev_out = 5'h0;
		foreach (rep_cnt[i]) rep_cnt[i] = 0;
	end
	always @(posedge clk_in) begin
		if (log_valid_in === 1'b1 && log_kind_in < 3'h7) begin
			rep_cnt[log_kind_in] <= rep_cnt[log_kind_in] + 1;
			rep_val[log_kind_in] <= log_value_in;
		end
	end
	// bits: 0 crc block error, 1 far-end bit, 2 frame loss, 3 signal loss, 4 alarm bit
	task automatic burst(input logic [4:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			ev_out <= m;
		end
		@(posedge clk_in);
		ev_out <= 5'h0;
	endtask
endmodule

// ---- tb_epm_monitor.sv ----
// Purpose: directed bench for the path performance monitor
// Assumes: one second shortened to SEC cycles
// Notes: quarter-hour and day boundaries are out of reach in a short run
`timescale 1ns/1ps
`include "epm_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t got %h want %h", $time, a, b); end end

module tb_epm_monitor;
	import epm_pkg::*;
	localparam int SEC = 900;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic ack, unav, lv;
	logic [31:0] rdat, lval, lst, q;
	epm_report_t lkind;
	logic [4:0] ev;
	logic [31:0] st = 32'h0;
	logic [31:0] e [5];
	logic [15:0] rv [5] = '{`EPM_RST_LIM_ES15, `EPM_RST_LIM_SES15, `EPM_RST_LIM_W, `EPM_RST_LIM_ES24, `EPM_RST_LIM_SES24};
	logic [15:0] wv [5] = '{16'h0003, 16'h0001, 16'h0014, 16'h0003, 16'h0001};
	int ec [7] = '{1, 1, 0, 0, 1, 1, 0};
	int err_total = 0;
	int total_checks = 0;

	always #5 clk_in = ~clk_in;
	// last report stamp seen on the log port
	always @(posedge clk_in) begin
		if (lv === 1'b1) begin
			st <= lst;
		end
	end

	epm_monitor #(.SEC_CYCLES(SEC), .RAI_SES_LIMIT(16'h0005)) uut (
		.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_ack_out(ack), .wb_dat_out(rdat),
		.crc_block_err_in(ev[0]), .far_block_err_in(ev[1]), .frame_align_lost_in(ev[2]),
		.signal_lost_in(ev[3]), .remote_alarm_in(ev[4]), .log_valid_out(lv), .log_kind_out(lkind),
		.log_value_out(lval), .log_stamp_out(lst), .path_unavail_out(unav)
	);
	epm_framer_model fr (.clk_in(clk_in), .ev_out(ev), .log_valid_in(lv), .log_kind_in(lkind), .log_value_in(lval));

	// ---------------------------------------------------------------
	// bus, timing and verdict tasks
	// ---------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// the time-of-day register is the only view of the second tick
	task automatic next_sec();
		logic [31:0] t0, t1;
		xfer(1'b0, `EPM_REG_TOD, 32'h0, t0);
		t1 = t0;
		for (int i = 0; i < 400 && t1 === t0; i++) xfer(1'b0, `EPM_REG_TOD, 32'h0, t1);
		if (t1 === t0) err_total++;
	endtask
	task automatic sec(input logic [4:0] m, input int n, input logic es, input logic severe_errored_second, input int b);
		fr.burst(m, n);
		next_sec();
		e[0] += 32'(es);
		e[1] += 32'(severe_errored_second);
		e[2] += 32'(es);
		e[3] += 32'(severe_errored_second);
		e[4] += 32'(b);
		for (int k = 0; k < 5; k++) begin
			xfer(1'b0, 8'(`EPM_REG_C1 + 4 * k), 32'h0, q);
			`CHK(q, e[k])
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#(60 * SEC * 10);
		err_total++;
		give_verdict();
	end

	initial begin
		foreach (e[k]) e[k] = 32'h0;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			xfer(1'b0, 8'(`EPM_REG_LIM_ES15 + 4 * k), 32'h0, q);
			`CHK(q, {16'h0, rv[k]})
			xfer(1'b1, 8'(`EPM_REG_LIM_ES15 + 4 * k), {16'hFFFF, wv[k]}, q);
		end
		xfer(1'b0, `EPM_REG_LIM_ES24, 32'h0, q);
		`CHK(q, 32'h3)
		xfer(1'b0, 8'h3C, 32'h0, q);
		`CHK(q, 32'h0)
		xfer(1'b1, `EPM_REG_C1, 32'h55, q);
		next_sec();
		sec(5'h01, 1, 1'b1, 1'b0, 1);
		sec(5'h01, 804, 1'b1, 1'b0, 804);
		sec(5'h01, 805, 1'b1, 1'b1, 0);
		sec(5'h02, 829, 1'b1, 1'b0, 0);
		`CHK(fr.rep_val[0], 32'h4)
		`CHK(fr.rep_val[4], 32'h4)
		`CHK(st, 32'h4)
		sec(5'h02, 830, 1'b1, 1'b1, 0);
		`CHK(fr.rep_val[1], 32'h2)
		`CHK(fr.rep_val[5], 32'h2)
		`CHK(st, 32'h5)
		sec(5'h10, 5, 1'b1, 1'b1, 0);
		sec(5'h04, 1, 1'b1, 1'b1, 0);
		sec(5'h08, 1, 1'b1, 1'b1, 0);
		sec(5'h10, 1, 1'b1, 1'b0, 0);
		for (int i = 1; i <= 10; i++) begin
			sec(5'h08, 1, 1'(i < 10), 1'(i < 10), 0);
			`CHK(unav, 1'(i == 10))
		end
		xfer(1'b0, `EPM_REG_STATUS, 32'h0, q);
		`CHK(q & 32'h7, 32'h5)
		for (int i = 1; i <= 10; i++) begin
			sec(i == 1 ? 5'h01 : 5'h00, 1, 1'b0, 1'b0, 0);
			`CHK(unav, 1'(i < 10))
		end
		sec(5'h01, 1, 1'b1, 1'b0, 1);
		xfer(1'b1, `EPM_REG_CTRL, 32'h3, q);
		e[4] = 32'h0;
		xfer(1'b0, `EPM_REG_BBE, 32'h0, q);
		`CHK(q, e[4])
		xfer(1'b0, `EPM_REG_CTRL, 32'h0, q);
		`CHK(q, 32'h1)
		xfer(1'b0, `EPM_REG_STATUS, 32'h0, q);
		`CHK(q, 32'h78)
		for (int k = 0; k < 7; k++) begin
			`CHK(fr.rep_cnt[k], ec[k])
		end
		give_verdict();
	end
endmodule
